// ===== rtl/cpm_clock_power_ctrl.sv
/*
 * clock source switch, peripheral dividers and power mode sequencer.
 * assumes oscillator waveforms and status pins are asynchronous to clk,
 * and an AXI4-Lite master on clk.
 */
// The address map and register access over AXI4-Lite were decided locally.
`default_nettype none
module cpm_clock_power_ctrl import cpm_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire cpm_axi_req_t axi_in,
	output var cpm_axi_rsp_t axi_out,
	input wire logic [3:0] osc_in,
	input wire logic [3:0] osc_ready,
	input wire logic wake_event,
	input wire logic wic_wake,
	input wire logic supply_ok,
	input wire logic brownout,
	output logic high_freq_system_clock,
	output logic [NUM_DIV-1:0] peri_clk_en,
	output logic radio_ref_clk,
	output logic cpu_clk_en,
	output logic cpu_pwr_en,
	output logic [1:0] hf_osc_en,
	output logic [2:0] main_internal_osc_freq,
	output logic bod_reset
);
	logic [SYNC_W-1:0] sync1, sync2;
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] div_cfg [NUM_DIV];
	logic [31:0] next_div_cfg [NUM_DIV];
	logic aw_hold, next_aw_hold, w_hold, next_w_hold;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic sleep_cmd, next_sleep_cmd, deep_cmd, next_deep_cmd, deep_pend, next_deep_pend;
	cpm_axi_rsp_t next_rsp;
	cpm_pm_t pm, next_pm;
	logic [10:0] wake_cnt, next_wake_cnt;
	logic next_cpu_clk_en, next_cpu_pwr_en, next_bod_reset;
	logic [1:0] next_hf_osc_en;
	cpm_src_t cur_src, next_cur_src;
	logic gate, next_gate, next_hf_out, peri_prev, next_peri_prev;
	logic src_now, want_on, peri_edge;
	// two-flop synchronisers, radio reference from crystal only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
			radio_ref_clk <= 1'b0;
		end else begin
			sync1 <= {brownout, supply_ok, wic_wake, wake_event, osc_ready, osc_in};
			sync2 <= sync1;
			radio_ref_clk <= sync2[SRC_XTAL];
		end
	end
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction
	function automatic logic div_hit(input logic [7:0] a);
		return a[7:5] == DIV_PAGE && a[1:0] == 2'b00;
	endfunction
	// register bus
	always_comb begin
		logic [31:0] v;
		v = '0;
		next_ctrl = ctrl;
		next_div_cfg = div_cfg;
		next_aw_hold = aw_hold;
		next_aw_addr = aw_addr;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_sleep_cmd = 1'b0;
		next_deep_cmd = 1'b0;
		next_rsp = axi_out;
		if (axi_in.awvalid && axi_out.awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = axi_in.awaddr;
		end
		if (axi_in.wvalid && axi_out.wready) begin
			next_w_hold = 1'b1;
			next_w_data = axi_in.wdata;
			next_w_strb = axi_in.wstrb;
		end
		if (axi_out.bvalid && axi_in.bready) begin
			next_rsp.bvalid = 1'b0;
		end
		if (next_aw_hold && next_w_hold && !next_rsp.bvalid) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_rsp.bvalid = 1'b1;
			next_rsp.bresp = RESP_OKAY;
			if (next_aw_addr == ADDR_CTRL) begin
				v = merge(ctrl, next_w_data, next_w_strb) & CTRL_MASK;
				if (v[TRIM_POS+:3] > TRIM_MAX) begin
					v[TRIM_POS+:3] = TRIM_MAX;
				end
				next_ctrl = v;
			end else if (next_aw_addr == ADDR_MODE) begin
				if (next_w_strb[0]) begin
					next_sleep_cmd = next_w_data[MODE_SLEEP_POS];
					next_deep_cmd = next_w_data[MODE_DEEP_POS];
				end
			end else if (div_hit(next_aw_addr)) begin
				v = merge(div_cfg[next_aw_addr[4:2]], next_w_data, next_w_strb);
				next_div_cfg[next_aw_addr[4:2]] = v &
					(32'(next_aw_addr[4:2]) < NUM_FRAC ? DIV_MASK_FRAC : DIV_MASK_INT);
			end else if (next_aw_addr != ADDR_STAT) begin
				next_rsp.bresp = RESP_SLVERR;
			end
		end
		next_rsp.awready = !next_aw_hold && !next_rsp.bvalid;
		next_rsp.wready = !next_w_hold && !next_rsp.bvalid;
		if (axi_out.rvalid && axi_in.rready) begin
			next_rsp.rvalid = 1'b0;
		end
		if (axi_in.arvalid && axi_out.arready) begin
			next_rsp.rvalid = 1'b1;
			next_rsp.rresp = RESP_OKAY;
			next_rsp.rdata = '0;
			if (axi_in.araddr == ADDR_CTRL) begin
				next_rsp.rdata = ctrl;
			end else if (axi_in.araddr == ADDR_STAT) begin
				next_rsp.rdata = {22'h0, gate, 1'b0, 2'b00, cur_src, 1'b0, pm};
			end else if (div_hit(axi_in.araddr)) begin
				next_rsp.rdata = div_cfg[axi_in.araddr[4:2]];
			end else if (axi_in.araddr != ADDR_MODE) begin
				next_rsp.rresp = RESP_SLVERR;
			end
		end
		next_rsp.arready = !next_rsp.rvalid;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RST;
			div_cfg <= '{default: DIV_RST};
			aw_hold <= 1'b0;
			aw_addr <= '0;
			w_hold <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			sleep_cmd <= 1'b0;
			deep_cmd <= 1'b0;
			axi_out <= '0;
		end else begin
			ctrl <= next_ctrl;
			div_cfg <= next_div_cfg;
			aw_hold <= next_aw_hold;
			aw_addr <= next_aw_addr;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			sleep_cmd <= next_sleep_cmd;
			deep_cmd <= next_deep_cmd;
			axi_out <= next_rsp;
		end
	end
	// power mode sequencer
	always_comb begin
		next_pm = pm;
		next_wake_cnt = wake_cnt;
		unique case (pm)
			PM_HOLD: next_pm = PM_ACTIVE;
			PM_ACTIVE: begin
				// deep entry waits until the gate has shut on a low phase
				if ((deep_cmd || deep_pend) && !gate) begin
					next_pm = PM_DEEP;
				end else if (sleep_cmd && !deep_cmd && !deep_pend) begin
					next_pm = PM_SLEEP;
				end
			end
			PM_SLEEP: begin
				if (sync2[S_WAKE]) begin
					next_pm = PM_ACTIVE;
				end
			end
			PM_DEEP: begin
				if (sync2[S_WIC]) begin
					next_pm = PM_WAKE;
					next_wake_cnt = 11'(WAKE_CYC - 1);
				end
			end
			PM_WAKE: begin
				if (wake_cnt != '0) begin
					next_wake_cnt = wake_cnt - 11'h1;
				end else if (gate && cur_src == cpm_src_t'(ctrl[SYS_SRC_POS+:2])) begin
					next_pm = PM_ACTIVE;
				end
			end
			default: next_pm = PM_HOLD;
		endcase
		if (sync2[S_BROWN] || !sync2[S_SUPPLY]) begin
			next_pm = PM_HOLD;
		end
		next_bod_reset = sync2[S_BROWN];
		next_cpu_clk_en = next_pm == PM_ACTIVE;
		next_cpu_pwr_en = next_pm != PM_DEEP;
		next_hf_osc_en = next_pm == PM_DEEP ? 2'b00 : 2'b11;
		next_deep_pend = (deep_cmd || deep_pend) && pm == PM_ACTIVE && next_pm == PM_ACTIVE;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pm <= PM_HOLD;
			wake_cnt <= '0;
			deep_pend <= 1'b0;
			cpu_clk_en <= 1'b0;
			cpu_pwr_en <= 1'b1;
			hf_osc_en <= 2'b11;
			bod_reset <= 1'b0;
			main_internal_osc_freq <= CTRL_RST[TRIM_POS+:3];
		end else begin
			pm <= next_pm;
			wake_cnt <= next_wake_cnt;
			deep_pend <= next_deep_pend;
			cpu_clk_en <= next_cpu_clk_en;
			cpu_pwr_en <= next_cpu_pwr_en;
			hf_osc_en <= next_hf_osc_en;
			bod_reset <= next_bod_reset;
			main_internal_osc_freq <= ctrl[TRIM_POS+:3];
		end
	end
	// glitch-free source switch: gate moves only while the source is low
	always_comb begin
		src_now = sync2[cur_src];
		want_on = (pm == PM_ACTIVE && !deep_cmd && !deep_pend) || pm == PM_SLEEP ||
			(pm == PM_WAKE && sync2[S_READY + 32'(ctrl[SYS_SRC_POS+:2])]);
		next_cur_src = cur_src;
		next_gate = gate;
		if (gate) begin
			if ((cur_src != cpm_src_t'(ctrl[SYS_SRC_POS+:2]) || !want_on) && !src_now) begin
				next_gate = 1'b0;
			end
		end else if (want_on && !sync2[ctrl[SYS_SRC_POS+:2]]) begin
			next_cur_src = cpm_src_t'(ctrl[SYS_SRC_POS+:2]);
			next_gate = 1'b1;
		end
		next_hf_out = next_gate && sync2[next_cur_src];
		if (ctrl[PERI_SRC_POS+:3] == PERI_FROM_SYS) begin
			next_peri_prev = high_freq_system_clock;
		end else begin
			next_peri_prev = sync2[ctrl[PERI_SRC_POS+:2]];
		end
		peri_edge = next_peri_prev && !peri_prev;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_src <= SRC_MAIN;
			gate <= 1'b0;
			high_freq_system_clock <= 1'b0;
			peri_prev <= 1'b0;
		end else begin
			cur_src <= next_cur_src;
			gate <= next_gate;
			high_freq_system_clock <= next_hf_out;
			peri_prev <= next_peri_prev;
		end
	end
	// peripheral dividers, period = int + 1 plus one when fraction carries
	for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
		logic [15:0] cnt, next_cnt;
		logic [4:0] acc, next_acc;
		logic carry, next_carry, pulse, next_pulse;
		always_comb begin
			logic [5:0] sum;
			sum = {1'b0, acc} + {1'b0, div_cfg[i][DIV_FRAC_POS+:5]};
			next_cnt = cnt;
			next_acc = acc;
			next_carry = carry;
			next_pulse = 1'b0;
			if (!div_cfg[i][DIV_EN_POS]) begin
				next_cnt = '0;
				next_acc = '0;
				next_carry = 1'b0;
			end else if (peri_edge) begin
				if ({1'b0, cnt} >= {1'b0, div_cfg[i][15:0]} + {16'h0, carry}) begin
					next_cnt = '0;
					next_pulse = 1'b1;
					next_acc = sum[4:0];
					next_carry = sum[5];
				end else begin
					next_cnt = cnt + 16'h1;
				end
			end
		end
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt <= '0;
				acc <= '0;
				carry <= 1'b0;
				pulse <= 1'b0;
			end else begin
				cnt <= next_cnt;
				acc <= next_acc;
				carry <= next_carry;
				pulse <= next_pulse;
			end
		end
		assign peri_clk_en[i] = pulse;
	end
	// checks
	a_bod_reset: assert property (@(posedge clk) disable iff (!rst_n)
		sync2[S_BROWN] |=> bod_reset && pm == PM_HOLD)
		else $error("brown-out did not reset");
	a_supply_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!sync2[S_SUPPLY] |=> pm == PM_HOLD && !cpu_clk_en)
		else $error("mode entered without supply");
	a_radio_xtal: assert property (@(posedge clk) disable iff (!rst_n)
		radio_ref_clk == $past(sync2[SRC_XTAL]))
		else $error("radio reference not from crystal");
	a_sleep_gate: assert property (@(posedge clk) disable iff (!rst_n)
		pm != PM_ACTIVE |-> !cpu_clk_en)
		else $error("processor clocked outside active");
	a_sleep_wake: assert property (@(posedge clk) disable iff (!rst_n)
		pm == PM_SLEEP && sync2[S_WAKE] && sync2[S_SUPPLY] && !sync2[S_BROWN]
		|=> pm == PM_ACTIVE ##0 cpu_clk_en)
		else $error("sleep wake not immediate");
	a_deep_off: assert property (@(posedge clk) disable iff (!rst_n)
		pm == PM_DEEP |-> hf_osc_en == 2'b00 && !cpu_pwr_en && !high_freq_system_clock)
		else $error("high-speed clock alive in deep sleep");
	a_wake_time: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pm == PM_WAKE) |-> wake_cnt == 11'(WAKE_CYC - 1) ##1 pm == PM_WAKE [*8])
		else $error("deep sleep exit too short");
	a_wake_stable: assert property (@(posedge clk) disable iff (!rst_n)
		$past(pm) == PM_WAKE && pm == PM_ACTIVE |-> $past(gate) && $past(wake_cnt) == '0)
		else $error("processor released before clock stable");
	a_clean_rise: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(gate) |-> !high_freq_system_clock && $past(!sync2[next_cur_src]))
		else $error("clock gate opened on high source");
	a_clean_fall: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(gate) |-> !high_freq_system_clock && $stable(cur_src))
		else $error("clock gate closed on high source");
	a_trim_range: assert property (@(posedge clk) disable iff (!rst_n)
		main_internal_osc_freq <= TRIM_MAX)
		else $error("main oscillator setting out of range");
endmodule
`default_nettype wire

// ===== rtl/cpm_pkg.sv
/*
 * constants, types and register map of the clock and power mode controller.
 * assumes one 50 MHz clock and an AXI4-Lite master with 8-bit byte addresses.
 */
// What this block does
// - system and peripheral clocks pick crystal, main internal, 40 kHz or 32 kHz source.
// - source changes never glitch the delivered clock; crossings are synchronised.
// - the high-frequency system clock is divided into synchronous peripheral clocks.
// - eight 16-bit peripheral dividers; exactly two also divide fractionally.
// - main internal oscillator resets to 24 MHz, adjustable 24 to 48 MHz in 4 MHz steps.
// - radio synthesizer reference comes only from the crystal oscillator.
// - Active, Sleep and Deep Sleep modes; both sleep modes are entered from and return to Active; Active clocks everything.
// - Sleep gates processor, flash and SRAM clocks; any wake-up event wakes at once (the code wakes Sleep on wake_event only, not on wic_wake).
// - Deep Sleep turns off the high-speed clock; return takes 35 us.
// - wake-up interrupt controller wakes from Deep Sleep; processor power may be removed.
// - mode entry waits for adequate supply; brown-out issues a reset.
`default_nettype none
package cpm_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [2:0] DIV_PAGE = 3'h1;
	// control fields
	localparam int SYS_SRC_POS = 0;
	localparam int PERI_SRC_POS = 4;
	localparam int TRIM_POS = 8;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0773;
	localparam logic [31:0] CTRL_RST = 32'h0000_0041;
	localparam logic [2:0] TRIM_MAX = 3'h6;
	localparam logic [2:0] PERI_FROM_SYS = 3'h4;
	// mode command bits
	localparam int MODE_SLEEP_POS = 0;
	localparam int MODE_DEEP_POS = 1;
	// divider fields
	localparam int NUM_DIV = 8;
	localparam int NUM_FRAC = 2;
	localparam int DIV_FRAC_POS = 16;
	localparam int DIV_EN_POS = 31;
	localparam logic [31:0] DIV_MASK_INT = 32'h8000_FFFF;
	localparam logic [31:0] DIV_MASK_FRAC = 32'h801F_FFFF;
	localparam logic [31:0] DIV_RST = 32'h0000_0000;
	// synchroniser vector layout
	localparam int SYNC_W = 12;
	localparam int S_READY = 4;
	localparam int S_WAKE = 8;
	localparam int S_WIC = 9;
	localparam int S_SUPPLY = 10;
	localparam int S_BROWN = 11;
	// timing
	localparam int CLK_MHZ = 50;
	localparam int WAKE_US = 35;
	localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		SRC_XTAL = 2'b00,
		SRC_MAIN = 2'b01,
		SRC_LOWF = 2'b10,
		SRC_WATCH = 2'b11
	} cpm_src_t;

	typedef enum logic [2:0] {
		PM_HOLD = 3'b000,
		PM_ACTIVE = 3'b001,
		PM_SLEEP = 3'b010,
		PM_DEEP = 3'b011,
		PM_WAKE = 3'b100
	} cpm_pm_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} cpm_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cpm_axi_rsp_t;
endpackage
`default_nettype wire

// ===== verif/cpm_osc_model.sv
/*
 * oscillator and supply-side model for the clock and power controller.
 * assumes the controller's enables for crystal and main oscillator; the low
 * frequency and watch sources always run. edges never meet clk's rising edge.
 */
`default_nettype none
module cpm_osc_model (
	input wire logic [1:0] hf_osc_en,
	output logic [3:0] osc_in,
	output logic [3:0] osc_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF [4] = '{60, 80, 140, 180};
	logic [3:0] run;
	assign run = {2'b11, hf_osc_en};
	// ready settles 200 ns after enable, drops 200 ns after it
	assign #200 osc_ready = run;
	for (genvar g = 0; g < 4; g++) begin : gen_osc
		initial begin
			osc_in[g] = 1'b0;
			#7;
			// a stopped source parks low
			forever #(HALF[g]) osc_in[g] = (run[g] === 1'b1) ? ~osc_in[g] : 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/*
 * self-checking bench for the clock and power controller.
 * assumes the oscillator model on the source pins and an AXI4-Lite master here.
 */
`default_nettype none
module tb_top import cpm_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	cpm_axi_req_t req = '0;
	cpm_axi_rsp_t rsp;
	logic [3:0] osc_in, osc_ready;
	logic wake_event = 1'b0, wic_wake = 1'b0, supply_ok = 1'b0, brownout = 1'b0;
	logic hf_clk, radio_ref_clk, cpu_clk_en, cpu_pwr_en, bod_reset;
	logic [NUM_DIV-1:0] peri_clk_en;
	logic [1:0] hf_osc_en;
	logic [2:0] osc_freq;
	logic [2:0] xh = '0;
	logic mon = 1'b1;
	logic [31:0] rd;
	logic [1:0] rs;
	int fails = 0, check_count = 0, run_len = 0, n;
	int pc [NUM_DIV];

	always #10 clk = ~clk;

	cpm_clock_power_ctrl uut (.clk(clk), .rst_n(rst_n), .axi_in(req), .axi_out(rsp),
		.osc_in(osc_in), .osc_ready(osc_ready), .wake_event(wake_event), .wic_wake(wic_wake),
		.supply_ok(supply_ok), .brownout(brownout), .high_freq_system_clock(hf_clk),
		.peri_clk_en(peri_clk_en), .radio_ref_clk(radio_ref_clk), .cpu_clk_en(cpu_clk_en),
		.cpu_pwr_en(cpu_pwr_en), .hf_osc_en(hf_osc_en), .main_internal_osc_freq(osc_freq),
		.bod_reset(bod_reset));
	cpm_osc_model osc (.hf_osc_en(hf_osc_en), .osc_in(osc_in), .osc_ready(osc_ready));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				r = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
		chk("write answer", k < 50, 1);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				d = rsp.rdata;
				r = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
		chk("read answer", k < 50, 1);
	endtask

	task automatic count(input int cyc);
		pc = '{default: 0};
		repeat (cyc) begin
			@(negedge clk);
			for (int i = 0; i < NUM_DIV; i++) pc[i] += peri_clk_en[i];
		end
	endtask

	always @(posedge clk) xh <= {xh[1:0], osc_in[0]};

	// delivered clock high pulses never shorter than the fastest source's
	always @(posedge clk) begin
		if (hf_clk === 1'b1) begin
			run_len++;
		end else if (run_len != 0) begin
			if (mon) chk("hf pulse width", run_len >= 3, 1);
			run_len = 0;
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(ADDR_STAT, rd, rs);
		chk("mode before supply", rd[2:0], 0);
		rd_reg(ADDR_CTRL, rd, rs);
		chk("ctrl reset", rd, CTRL_RST);
		chk("osc freq reset", osc_freq, 0);
		supply_ok <= 1'b1;
		repeat (8) @(posedge clk);
		rd_reg(ADDR_STAT, rd, rs);
		chk("mode active", rd[2:0], 1);
		chk("cpu clock active", cpu_clk_en, 1);
		for (int t = 0; t < 8; t++) begin
			wr(ADDR_CTRL, {21'h0, t[2:0], 8'h41}, rs);
			repeat (5) @(posedge clk);
			chk("osc freq", osc_freq, (t > 6) ? 6 : t);
		end
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CTRL, {24'h0, 6'h10, s[1:0]}, rs);
			repeat (80) @(posedge clk);
			rd_reg(ADDR_STAT, rd, rs);
			chk("current source", rd[5:4], s);
		end
		repeat (30) begin
			@(negedge clk);
			chk("radio reference", radio_ref_clk, xh[2]);
		end
		wr(ADDR_CTRL, CTRL_RST, rs);
		repeat (60) @(posedge clk);
		for (int i = 0; i < NUM_DIV; i++) begin
			wr({DIV_PAGE, i[2:0], 2'b00}, 32'h801F_0001, rs);
			rd_reg({DIV_PAGE, i[2:0], 2'b00}, rd, rs);
			chk("divider readback", rd, (i < NUM_FRAC) ? 32'h801F_0001 : 32'h8000_0001);
		end
		count(400);
		for (int i = 0; i < NUM_DIV; i++) begin
			chk("divider rate", (i < NUM_FRAC) ? pc[i] < 22 : pc[i] inside {[24:26]}, 1);
		end
		rd_reg(8'h0C, rd, rs);
		chk("unmapped read", rs, RESP_SLVERR);
		wr(8'h0C, 32'h0, rs);
		chk("unmapped write", rs, RESP_SLVERR);
		wr(ADDR_MODE, 32'h1, rs);
		repeat (5) @(posedge clk);
		rd_reg(ADDR_STAT, rd, rs);
		chk("sleep mode", rd[2:0], 2);
		chk("cpu clock gated", cpu_clk_en, 0);
		count(100);
		chk("peripheral in sleep", pc[7] > 0, 1);
		@(posedge clk);
		wake_event <= 1'b1;
		repeat (6) @(posedge clk);
		chk("wake from sleep", cpu_clk_en, 1);
		wake_event <= 1'b0;
		wr(ADDR_MODE, 32'h2, rs);
		repeat (12) @(posedge clk);
		rd_reg(ADDR_STAT, rd, rs);
		chk("deep mode", rd[2:0], 3);
		chk("deep hf osc off", hf_osc_en, 0);
		chk("deep cpu power off", cpu_pwr_en, 0);
		wic_wake <= 1'b1;
		n = 0;
		while (cpu_clk_en !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("deep wake time", n >= WAKE_CYC && n <= 1850, 1);
		chk("hf osc back", hf_osc_en[1], 1);
		wic_wake <= 1'b0;
		mon = 1'b0;
		brownout <= 1'b1;
		repeat (6) @(posedge clk);
		chk("brownout reset", bod_reset, 1);
		chk("cpu clock held", cpu_clk_en, 0);
		rd_reg(ADDR_STAT, rd, rs);
		chk("hold on brownout", rd[2:0], 0);
		brownout <= 1'b0;
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		chk("watchdog", 0, 1);
		print_verdict();
	end
endmodule
`default_nettype wire
